// File: src/khig_top.sv
// Host interrupt generation for the keyboard and PM1 channels:
// register file, output-full flags and three shaped host lines.
// Assumes bus strobes and host read pulses come from core_clk logic.
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "khig_map.svh"

module khig_top (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Host side reads of the data outputs
	input  wire logic       host_kbd_rd,
	input  wire logic       host_pm1_rd,
	// Data and flags toward the host
	output logic      [7:0] kbd_host_data,
	output logic      [7:0] pm1_host_data,
	output logic            kbd_obf,
	output logic            pm1_obf,
	// Lines toward serial interrupt routing
	output logic            irq1_line,
	output logic            irq11_line,
	output logic            irq12_line
);
	import khig_pkg::*;

	// ****************************************************
	// Declarations
	// ****************************************************
	logic [7:0] host_side_irq_enables_reg;
	logic [7:0] host_irq_shape_control_reg;
	logic       aux_src_reg;
	logic       kbd_full_host_irq_en;
	logic       aux_full_host_irq_en;
	logic       pm_one_host_irq_en;
	logic       irq_invert;
	khig_mode_t irq_signal_mode;
	logic       line_one_direct_bit;
	logic       line_eleven_direct_bit;
	logic       line_twelve_direct_bit;
	logic       wr_enables;
	logic       wr_shape;
	logic       wr_kbd;
	logic       wr_aux;
	logic       wr_pm1;
	logic       line_one_cond;
	logic       line_eleven_cond;
	logic       line_twelve_cond;
	logic [7:0] rdata_next;

	// ****************************************************
	// Write decode
	// ****************************************************

	// One select per writable register
	always_comb begin
		wr_enables = 1'b0;
		wr_shape   = 1'b0;
		wr_kbd     = 1'b0;
		wr_aux     = 1'b0;
		wr_pm1     = 1'b0;
		if (reg_wr && reg_addr == `KHIG_OFS_ENABLES) begin
			wr_enables = 1'b1;
		end else if (reg_wr && reg_addr == `KHIG_OFS_SHAPE) begin
			wr_shape = 1'b1;
		end else if (reg_wr && reg_addr == `KHIG_OFS_KBD_DATA) begin
			wr_kbd = 1'b1;
		end else if (reg_wr && reg_addr == `KHIG_OFS_AUX_DATA) begin
			wr_aux = 1'b1;
		end else if (reg_wr && reg_addr == `KHIG_OFS_PM1_DATA) begin
			wr_pm1 = 1'b1;
		end
	end

	// ****************************************************
	// Control registers
	// ****************************************************

	// Enable register; bit 7 held at zero
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_side_irq_enables_reg <= `KHIG_ENABLES_RST;
		end else if (wr_enables) begin
			host_side_irq_enables_reg <= reg_wdata & `KHIG_WMASK;
		end
	end

	// Shape register; bit 7 held at zero, direct bits reset high
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_irq_shape_control_reg <= `KHIG_SHAPE_RST;
		end else if (wr_shape) begin
			host_irq_shape_control_reg <= reg_wdata & `KHIG_WMASK;
		end
	end

	// Field views
	assign kbd_full_host_irq_en =
		host_side_irq_enables_reg[`KHIG_BIT_KBD_EN];
	assign aux_full_host_irq_en =
		host_side_irq_enables_reg[`KHIG_BIT_AUX_EN];
	assign pm_one_host_irq_en =
		host_side_irq_enables_reg[`KHIG_BIT_PM1_EN];
	assign irq_invert = host_irq_shape_control_reg[`KHIG_BIT_INV];
	assign irq_signal_mode =
		host_irq_shape_control_reg[`KHIG_MODE_HI:`KHIG_MODE_LO];
	assign line_one_direct_bit =
		host_irq_shape_control_reg[`KHIG_BIT_L1];
	assign line_twelve_direct_bit =
		host_irq_shape_control_reg[`KHIG_BIT_L12];
	assign line_eleven_direct_bit =
		host_irq_shape_control_reg[`KHIG_BIT_L11];

	// ****************************************************
	// Output data and full flags
	// ****************************************************

	// Keyboard and aux share one data output toward the host
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			kbd_host_data <= 8'h00;
		end else if (wr_kbd || wr_aux) begin
			kbd_host_data <= reg_wdata;
		end
	end

	// PM1 data output toward the host
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pm1_host_data <= 8'h00;
		end else if (wr_pm1) begin
			pm1_host_data <= reg_wdata;
		end
	end

	// Remembers whether the last shared write came from aux
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aux_src_reg <= 1'b0;
		end else if (wr_aux) begin
			aux_src_reg <= 1'b1;
		end else if (wr_kbd) begin
			aux_src_reg <= 1'b0;
		end
	end

	khig_obf u_kbd_obf (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.set_pulse (wr_kbd || wr_aux),
		.clr_pulse (host_kbd_rd),
		.full_flag (kbd_obf)
	);

	khig_obf u_pm1_obf (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.set_pulse (wr_pm1),
		.clr_pulse (host_pm1_rd),
		.full_flag (pm1_obf)
	);

	// ****************************************************
	// Interrupt conditions and line shapers
	// ****************************************************

	// Buffer-full conditions per line
	assign line_one_cond    = kbd_obf && !aux_src_reg;
	assign line_twelve_cond = kbd_obf && aux_src_reg;
	assign line_eleven_cond = pm1_obf;

	khig_shaper u_line_one (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.cond       (line_one_cond),
		.auto_en    (kbd_full_host_irq_en),
		.direct_bit (line_one_direct_bit),
		.invert     (irq_invert),
		.mode       (irq_signal_mode),
		.line       (irq1_line)
	);

	khig_shaper u_line_eleven (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.cond       (line_eleven_cond),
		.auto_en    (pm_one_host_irq_en),
		.direct_bit (line_eleven_direct_bit),
		.invert     (irq_invert),
		.mode       (irq_signal_mode),
		.line       (irq11_line)
	);

	khig_shaper u_line_twelve (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.cond       (line_twelve_cond),
		.auto_en    (aux_full_host_irq_en),
		.direct_bit (line_twelve_direct_bit),
		.invert     (irq_invert),
		.mode       (irq_signal_mode),
		.line       (irq12_line)
	);

	// ****************************************************
	// Read path
	// ****************************************************

	// Read mux; direct bits read back the live line levels
	always_comb begin
		rdata_next = 8'h00;
		if (reg_addr == `KHIG_OFS_ENABLES) begin
			rdata_next = host_side_irq_enables_reg;
		end else if (reg_addr == `KHIG_OFS_SHAPE) begin
			rdata_next = {1'b0,
				host_irq_shape_control_reg[`KHIG_BIT_INV:`KHIG_MODE_LO],
				irq11_line, irq12_line, irq1_line};
		end else if (reg_addr == `KHIG_OFS_STATUS) begin
			rdata_next = {5'h00, pm1_obf, aux_src_reg, kbd_obf};
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************

	AST_TOP_RSVD_ZERO: assert property (@(posedge core_clk)
		disable iff (sys_rst) reg_rd |=> !reg_rdata[7])
		else $error("reserved bit read as one");

	AST_TOP_READBACK: assert property (@(posedge core_clk)
		disable iff (sys_rst) reg_rd && reg_addr == `KHIG_OFS_SHAPE
		|=> reg_rdata[2:0] == $past({irq11_line, irq12_line, irq1_line}))
		else $error("direct bits do not read back lines");

	AST_TOP_KBD_LEVEL: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		kbd_full_host_irq_en && irq_signal_mode == `KHIG_MODE_LEVEL &&
		!irq_invert && line_one_cond |=> irq1_line)
		else $error("line one not raised while keyboard full");

	AST_TOP_PM1_LEVEL: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		pm_one_host_irq_en && irq_signal_mode == `KHIG_MODE_LEVEL &&
		!irq_invert && pm1_obf |=> irq11_line)
		else $error("line eleven not raised while pm1 full");

	AST_TOP_AUX_INV: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		aux_full_host_irq_en && irq_signal_mode == `KHIG_MODE_LEVEL &&
		irq_invert && line_twelve_cond |=> !irq12_line)
		else $error("inverted line twelve not low");

	AST_TOP_WR_FULL: assert property (@(posedge core_clk)
		disable iff (sys_rst) wr_pm1 |=> pm1_obf ##0 pm1_host_data ==
		$past(reg_wdata))
		else $error("pm1 write did not fill buffer");

	AST_TOP_DIRECT_RST: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		$fell(sys_rst) |-> host_irq_shape_control_reg[2:0] == 3'h7)
		else $error("direct bits not reset high");

	AST_TOP_AUX_LEVEL: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		aux_full_host_irq_en && irq_signal_mode == `KHIG_MODE_LEVEL &&
		!irq_invert && line_twelve_cond |=> irq12_line)
		else $error("line twelve not raised while aux full");

	AST_TOP_L11_DIRECT: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		!pm_one_host_irq_en |=> irq11_line == $past(line_eleven_direct_bit))
		else $error("line eleven does not follow its bit");

	AST_TOP_RSVD_WR: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		wr_shape |=> !host_irq_shape_control_reg[7])
		else $error("reserved shape bit took a write");

endmodule // khig_top

// File: src/khig_map.svh
// Register map, field positions, reset values and pulse counts
// Assumes inclusion by the package, khig_top and khig_shaper
`ifndef KHIG_MAP_SVH
`define KHIG_MAP_SVH

// ****************************************************
// Register offsets
// ****************************************************
`define KHIG_OFS_ENABLES  8'h00
`define KHIG_OFS_SHAPE    8'h02
`define KHIG_OFS_STATUS   8'h04
`define KHIG_OFS_KBD_DATA 8'h06
`define KHIG_OFS_AUX_DATA 8'h08
`define KHIG_OFS_PM1_DATA 8'h0c

// ****************************************************
// Field positions
// ****************************************************
`define KHIG_BIT_KBD_EN   0
`define KHIG_BIT_AUX_EN   1
`define KHIG_BIT_PM1_EN   4
`define KHIG_BIT_INV      6
`define KHIG_MODE_HI      5
`define KHIG_MODE_LO      3
`define KHIG_BIT_L11      2
`define KHIG_BIT_L12      1
`define KHIG_BIT_L1       0

// ****************************************************
// Reset values and write masks
// ****************************************************
`define KHIG_ENABLES_RST  8'h00
`define KHIG_SHAPE_RST    8'h07
`define KHIG_WMASK        8'h7f

// ****************************************************
// Mode codes and edge pulse lengths in core_clk cycles
// ****************************************************
`define KHIG_MODE_LEVEL   3'h0
`define KHIG_MODE_E1      3'h1
`define KHIG_MODE_E2      3'h2
`define KHIG_MODE_E8      3'h5
`define KHIG_MODE_E16     3'h6
`define KHIG_LEN_1        5'h01
`define KHIG_LEN_2        5'h02
`define KHIG_LEN_8        5'h08
`define KHIG_LEN_16       5'h10

`endif

// File: src/khig_pkg.sv
// Types and decode functions shared by the host interrupt block
// Assumes khig_map.svh sits beside it
`include "khig_map.svh"

package khig_pkg;

	// Shaper states, Gray coded
	typedef enum logic [0:0] {
		KHIG_SH_IDLE  = 1'b0,
		KHIG_SH_PULSE = 1'b1
	} khig_shp_state_t;

	typedef logic [2:0] khig_mode_t;
	typedef logic [4:0] khig_len_t;

	// True for the four edge codes
	function automatic logic khig_is_edge(input khig_mode_t m);
		return (m == `KHIG_MODE_E1) || (m == `KHIG_MODE_E2) ||
		       (m == `KHIG_MODE_E8) || (m == `KHIG_MODE_E16);
	endfunction

	// Low pulse length for an edge code
	function automatic khig_len_t khig_pulse_len(input khig_mode_t m);
		khig_len_t l;
		l = `KHIG_LEN_1;
		case (m)
			`KHIG_MODE_E2:  l = `KHIG_LEN_2;
			`KHIG_MODE_E8:  l = `KHIG_LEN_8;
			`KHIG_MODE_E16: l = `KHIG_LEN_16;
			default:        l = `KHIG_LEN_1;
		endcase
		return l;
	endfunction

endpackage

// File: src/khig_obf.sv
// Output-full flag: set by firmware data write, cleared by host read
// Assumes set and clear are one-cycle pulses on core_clk
`timescale 1ns/10ps

module khig_obf (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// Events
	input  wire logic set_pulse,
	input  wire logic clr_pulse,
	// Flag
	output logic      full_flag
);
	import khig_pkg::*;

	// Set wins over a clear in the same cycle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			full_flag <= 1'b0;
		end else if (set_pulse) begin
			full_flag <= 1'b1;
		end else if (clr_pulse) begin
			full_flag <= 1'b0;
		end
	end

	AST_OBF_SET_WINS: assert property (@(posedge core_clk)
		disable iff (sys_rst) set_pulse |=> full_flag)
		else $error("full flag not set after write");

	AST_OBF_CLEAR: assert property (@(posedge core_clk)
		disable iff (sys_rst) clr_pulse && !set_pulse |=> !full_flag)
		else $error("full flag not cleared after host read");

endmodule // khig_obf

// File: src/khig_shaper.sv
// One host interrupt line: direct, level or edge pulse form
// Assumes cond comes from logic on core_clk
`timescale 1ns/10ps
`include "khig_map.svh"

module khig_shaper (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	// Source and settings
	input  wire logic              cond,
	input  wire logic              auto_en,
	input  wire logic              direct_bit,
	input  wire logic              invert,
	input  wire khig_pkg::khig_mode_t mode,
	// Line toward routing
	output logic                   line
);
	import khig_pkg::*;

	khig_shp_state_t state_reg;
	khig_len_t       cnt_reg;
	logic            cond_reg;
	logic            edge_mode;
	logic            start;

	// Rising condition starts a pulse in edge mode
	assign edge_mode = khig_is_edge(mode);
	assign start     = auto_en && edge_mode && cond && !cond_reg;

	// Condition history for edge detection
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cond_reg <= 1'b0;
		end else begin
			cond_reg <= cond;
		end
	end

	// Pulse sequencer, counted in core_clk cycles
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= KHIG_SH_IDLE;
			cnt_reg   <= 5'h00;
		end else begin
			case (state_reg)
				KHIG_SH_IDLE: begin
					if (start) begin
						state_reg <= KHIG_SH_PULSE;
						cnt_reg   <= khig_pulse_len(mode) - 5'h01;
					end
				end
				KHIG_SH_PULSE: begin
					if (cnt_reg == 5'h00) begin
						state_reg <= KHIG_SH_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 5'h01;
					end
				end
				default: state_reg <= KHIG_SH_IDLE;
			endcase
		end
	end

	// Line level; direct bit when auto is off; edge line idles high unless inverted
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			line <= 1'b1;
		end else if (!auto_en) begin
			line <= direct_bit;
		end else if (edge_mode) begin
			line <= (state_reg != KHIG_SH_PULSE) ^ invert;
		end else begin
			line <= cond ^ invert;
		end
	end

	AST_SHP_DIRECT: assert property (@(posedge core_clk)
		disable iff (sys_rst) !auto_en |=> line == $past(direct_bit))
		else $error("direct line does not follow its bit");

	AST_SHP_LEVEL: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		auto_en && mode == `KHIG_MODE_LEVEL |=> line == $past(cond ^ invert))
		else $error("level line does not follow condition");

	AST_SHP_E1: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		start && mode == `KHIG_MODE_E1 && !invert ##1 auto_en && !invert
		|=> !line ##1 line)
		else $error("one cycle pulse has wrong width");

	AST_SHP_E2: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		start && mode == `KHIG_MODE_E2 && !invert
		##1 (auto_en && edge_mode && !invert) [*3]
		|-> $past(!line) && !line ##1 line)
		else $error("two cycle pulse has wrong width");

	AST_SHP_IDLE_HIGH: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		auto_en && edge_mode && !invert && state_reg == KHIG_SH_IDLE
		|=> line)
		else $error("edge line not idle high");

endmodule // khig_shaper

// File: sim/khig_host_model.sv
// Host side model: reads the data outputs after a chosen lag
// Assumes go pulses are one core_clk cycle long, index 0 kbd, 1 pm1
`timescale 1ns/10ps

module khig_host_model (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// Commands from the bench
	input  wire logic [1:0] go,
	input  wire logic [3:0] lag,
	// Host reads toward the block
	output logic            host_kbd_rd,
	output logic            host_pm1_rd
);

	// ****************************************************
	// Delayed one-cycle read pulses
	// ****************************************************
	logic [1:0] wait_reg;
	logic [3:0] cnt_reg [2];
	logic [1:0] rd_reg;

	// Read clears the full flag on the block side
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wait_reg <= 2'h0;
			rd_reg   <= 2'h0;
			cnt_reg  <= '{4'h0, 4'h0};
		end else begin
			for (int i = 0; i < 2; i++) begin
				rd_reg[i] <= 1'b0;
				if (go[i]) begin
					wait_reg[i] <= 1'b1;
					cnt_reg[i]  <= lag;
				end else if (wait_reg[i]) begin
					if (cnt_reg[i] == 4'h0) begin
						rd_reg[i]   <= 1'b1;
						wait_reg[i] <= 1'b0;
					end else begin
						cnt_reg[i] <= cnt_reg[i] - 4'h1;
					end
				end
			end
		end
	end

	// Pulses out
	assign host_kbd_rd = rd_reg[0];
	assign host_pm1_rd = rd_reg[1];

endmodule // khig_host_model

// File: sim/khig_top_tb.sv
// Self-checking bench for the host interrupt block
// Assumes khig_top and khig_host_model are compiled before it
`timescale 1ns/10ps

module khig_top_tb;

	// ****************************************************
	// Signals
	// ****************************************************
	logic       core_clk = 1'b0;
	logic       sys_rst  = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic       host_kbd_rd;
	logic       host_pm1_rd;
	logic [7:0] kbd_host_data;
	logic [7:0] pm1_host_data;
	logic       kbd_obf;
	logic       pm1_obf;
	logic       irq1_line;
	logic       irq11_line;
	logic       irq12_line;
	logic [7:0] lines;
	logic [1:0] go = 2'h0;
	logic [3:0] lag = 4'h0;
	int         n_errors = 0;
	int         n_checks = 0;
	int         cnt;
	logic [7:0] shapes [5] = '{8'h08, 8'h10, 8'h28, 8'h30, 8'h48};
	logic [7:0] lens   [5] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h01};

	khig_top dut (
		.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.host_kbd_rd(host_kbd_rd), .host_pm1_rd(host_pm1_rd),
		.kbd_host_data(kbd_host_data), .pm1_host_data(pm1_host_data),
		.kbd_obf(kbd_obf), .pm1_obf(pm1_obf), .irq1_line(irq1_line),
		.irq11_line(irq11_line), .irq12_line(irq12_line)
	);

	khig_host_model host (
		.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .lag(lag),
		.host_kbd_rd(host_kbd_rd), .host_pm1_rd(host_pm1_rd)
	);

	// Clock at 125 MHz
	always #4 core_clk = ~core_clk;

	// All three lines as one byte: eleven, twelve, one
	assign lines = {5'h0, irq11_line, irq12_line, irq1_line};

	// ****************************************************
	// Tasks
	// ****************************************************
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1;
		chk("reg_rdata", reg_rdata, exp);
	endtask

	// Host read through the model, then wait for the flag to drop
	task automatic host_rd(input int ch, input logic [3:0] l);
		@(posedge core_clk);
		lag    <= l;
		go[ch] <= 1'b1;
		@(posedge core_clk);
		go     <= 2'h0;
		for (int i = 0; i < 30 && (ch ? pm1_obf : kbd_obf) !== 1'b0; i++)
			@(posedge core_clk);
		settle(1);
		chk("obf_clear", {7'h0, ch ? pm1_obf : kbd_obf}, 8'h00);
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		test_done;
	end

	// ****************************************************
	// Tests
	// ****************************************************
	initial begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		settle(1);
		chk("lines_rst", lines, 8'h07);
		rd(8'h02, 8'h07);
		settle(1);
		chk("rdata_gone", reg_rdata, 8'h00);
		rd(8'h00, 8'h00);
		// Direct control, invert and bit 7 ignored
		wr(8'h02, 8'hc2);
		settle(2);
		chk("lines_dir", lines, 8'h02);
		rd(8'h02, 8'h42);
		wr(8'h02, 8'h05);
		settle(2);
		chk("lines_dir2", lines, 8'h05);
		rd(8'h02, 8'h05);
		// Keyboard level mode
		wr(8'h00, 8'h81);
		rd(8'h00, 8'h01);
		wr(8'h02, 8'h00);
		settle(2);
		chk("l1_idle", {7'h0, irq1_line}, 8'h00);
		wr(8'h06, 8'ha5);
		settle(2);
		chk("kbd_data", kbd_host_data, 8'ha5);
		chk("l1_level", {7'h0, irq1_line}, 8'h01);
		chk("l12_dir", {7'h0, irq12_line}, 8'h00);
		rd(8'h04, 8'h01);
		host_rd(0, 4'h3);
		settle(1);
		chk("l1_drop", {7'h0, irq1_line}, 8'h00);
		wr(8'h02, 8'h40);
		settle(2);
		chk("l1_inv_idle", {7'h0, irq1_line}, 8'h01);
		wr(8'h06, 8'h11);
		settle(2);
		chk("l1_inv_on", {7'h0, irq1_line}, 8'h00);
		host_rd(0, 4'h0);
		// Aux channel on line twelve
		wr(8'h00, 8'h02);
		wr(8'h02, 8'h00);
		wr(8'h08, 8'h5a);
		settle(2);
		chk("l12_auto", {7'h0, irq12_line}, 8'h01);
		chk("l1_dir0", {7'h0, irq1_line}, 8'h00);
		rd(8'h04, 8'h03);
		host_rd(0, 4'h0);
		settle(1);
		chk("l12_drop", {7'h0, irq12_line}, 8'h00);
		// PM1 channel on line eleven
		wr(8'h00, 8'h10);
		wr(8'h0c, 8'h77);
		settle(2);
		chk("pm1_data", pm1_host_data, 8'h77);
		chk("l11_auto", {7'h0, irq11_line}, 8'h01);
		host_rd(1, 4'h2);
		settle(1);
		chk("l11_drop", {7'h0, irq11_line}, 8'h00);
		// Write-only and unmapped places
		rd(8'h0e, 8'h00);
		rd(8'h06, 8'h00);
		// Edge modes and pulse widths
		wr(8'h00, 8'h01);
		for (int k = 0; k < 5; k++) begin
			wr(8'h02, shapes[k]);
			settle(2);
			chk("e_idle", {7'h0, irq1_line}, {7'h0, ~shapes[k][6]});
			wr(8'h06, 8'h3c);
			cnt = 0;
			repeat (40) begin
				@(posedge core_clk);
				#1;
				if (irq1_line !== ~shapes[k][6])
					cnt++;
			end
			chk("e_len", cnt[7:0], lens[k]);
			host_rd(0, 4'h0);
		end
		// Reserved mode code falls back to level behaviour
		wr(8'h02, 8'h38);
		wr(8'h06, 8'h01);
		settle(2);
		chk("rsvd_level", {7'h0, irq1_line}, 8'h01);
		host_rd(0, 4'h0);
		settle(1);
		chk("rsvd_drop", {7'h0, irq1_line}, 8'h00);
		test_done;
	end

endmodule // khig_top_tb
